// >>> rtl/frt_params.svh
// Offsets, field positions, reset values and timing counts of the free-running timer
`ifndef FRT_PARAMS_SVH
`define FRT_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define FRT_OFS_FLAGS      8'h00
`define FRT_OFS_COUNT      8'h04
`define FRT_OFS_CMP_A      8'h08
`define FRT_OFS_CMP_B      8'h0C
`define FRT_OFS_IRQ_MASK   8'h10
`define FRT_OFS_IRQ_STAT   8'h14

// ==========================================================
// Field positions, shared by flags, mask and interrupt status except clear-A, which is in flags only
`define FRT_BIT_CMP_A      3
`define FRT_BIT_CMP_B      2
`define FRT_BIT_WRAP       1
`define FRT_BIT_CLR_A      0

// ==========================================================
// Reset values
`define FRT_RST_FLAGS      8'h00
`define FRT_RST_COUNT      16'h0000
`define FRT_RST_CMP        16'hFFFF
`define FRT_RST_MASK       8'h00
`define FRT_COUNT_MAX      16'hFFFF

// ==========================================================
// Timing: count clock period in ns, divider derived from 20 MHz
`define FRT_CLK_NS         50
`define FRT_TICK_NS        50
`define FRT_TICK_DIV       ((`FRT_TICK_NS + `FRT_CLK_NS - 1) / `FRT_CLK_NS)

`endif

// >>> rtl/frt_pkg.sv
// Types shared by the free-running timer
package frt_pkg;

	// ==========================================================
	// Wishbone classic request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} wb_req_t;

	// ==========================================================
	// Hardware event flags
	typedef struct packed {
		logic cmp_a;
		logic cmp_b;
		logic wrap;
	} timer_flags_t;

endpackage : frt_pkg

// >>> rtl/free_running_timer_status.sv
// Free-running 16-bit timer with compare flags, counter clear and Wishbone registers
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`include "frt_params.svh"

module free_running_timer_status
	import frt_pkg::*;
#(
	parameter int unsigned TICK_DIV = `FRT_TICK_DIV
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire wb_req_t     i_wb,
	output logic             o_wb_ack,
	output logic [31:0]      o_wb_dat,
	output logic             o_irq
);

	// ==========================================================
	// State
	timer_flags_t flags_reg;
	timer_flags_t armed_reg;
	timer_flags_t irq_stat_reg;
	timer_flags_t irq_mask_reg;
	logic         clr_a_reg;
	logic [15:0]  count_reg;
	logic [15:0]  cmp_a_reg;
	logic [15:0]  cmp_b_reg;
	logic [7:0]   div_reg;
	logic         ack_reg;
	logic [31:0]  dat_reg;

	// ==========================================================
	// Bus decode
	wire logic       req       = i_wb.cyc & i_wb.stb;
	wire logic       commit    = req & ack_reg;
	wire logic       wr_commit = commit & i_wb.we;
	wire logic       rd_commit = commit & ~i_wb.we;
	wire logic [7:0] ofs       = {i_wb.adr[7:2], 2'b00};
	wire logic       sel_flags = (ofs == `FRT_OFS_FLAGS);
	wire logic       sel_count = (ofs == `FRT_OFS_COUNT);
	wire logic       sel_cmp_a = (ofs == `FRT_OFS_CMP_A);
	wire logic       sel_cmp_b = (ofs == `FRT_OFS_CMP_B);
	wire logic       sel_mask  = (ofs == `FRT_OFS_IRQ_MASK);
	wire logic       sel_stat  = (ofs == `FRT_OFS_IRQ_STAT);
	wire logic       wr_lane0  = wr_commit & i_wb.sel[0];
	wire logic       cnt_wr    = wr_commit & sel_count & (|i_wb.sel[1:0]);

	function automatic logic [15:0] merge16(input logic [15:0] old, input wb_req_t w);
		merge16 = {w.sel[1] ? w.dat[15:8] : old[15:8], w.sel[0] ? w.dat[7:0] : old[7:0]};
	endfunction : merge16

	// ==========================================================
	// Count clock divider
	wire logic tick = (div_reg == 8'(TICK_DIV - 1));

	always_ff @(posedge i_clk) begin
		if (i_rst || tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// ==========================================================
	// Counter and match detection
	wire logic   match_a = tick & (count_reg == cmp_a_reg);
	wire logic   match_b = tick & (count_reg == cmp_b_reg);
	wire logic   clr_hit = match_a & clr_a_reg;
	wire logic   wrap    = tick & ~clr_hit & (count_reg == `FRT_COUNT_MAX);
	logic [15:0] count_next;

	// A software write to the count wins over a tick in the same cycle
	always_comb begin
		count_next = count_reg;
		if (cnt_wr) begin
			count_next = merge16(count_reg, i_wb);
		end else if (clr_hit) begin
			count_next = `FRT_RST_COUNT;
		end else if (tick) begin
			count_next = count_reg + 16'h0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count_reg <= `FRT_RST_COUNT;
		end else begin
			count_reg <= count_next;
		end
	end

	// ==========================================================
	// Flags: set wins over clear
	timer_flags_t ev;
	timer_flags_t wr0;
	timer_flags_t flags_next;
	timer_flags_t armed_next;
	wire logic    flag_wr = wr_lane0 & sel_flags;

	assign ev  = '{cmp_a: match_a, cmp_b: match_b, wrap: wrap};
	assign wr0 = '{cmp_a: ~i_wb.dat[`FRT_BIT_CMP_A],
	               cmp_b: ~i_wb.dat[`FRT_BIT_CMP_B],
	               wrap:  ~i_wb.dat[`FRT_BIT_WRAP]};

	// Only a zero written to a flag that was seen as one clears it
	assign flags_next = ev | (flags_reg & ~(flag_wr ? (wr0 & armed_reg) : 3'b000));
	assign armed_next = flag_wr ? 3'b000 :
	                    (rd_commit & sel_flags) ? (armed_reg | flags_reg) : armed_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flags_reg <= 3'b000;
			armed_reg <= 3'b000;
		end else begin
			flags_reg <= flags_next;
			armed_reg <= armed_next;
		end
	end

	// ==========================================================
	// Control, compare and interrupt registers
	wire logic [7:0] stat_w1c = (wr_lane0 & sel_stat) ? i_wb.dat[7:0] : 8'h00;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			clr_a_reg    <= 1'b0;
			cmp_a_reg    <= `FRT_RST_CMP;
			cmp_b_reg    <= `FRT_RST_CMP;
			irq_mask_reg <= 3'b000;
			irq_stat_reg <= 3'b000;
		end else begin
			if (flag_wr) begin
				clr_a_reg <= i_wb.dat[`FRT_BIT_CLR_A];
			end
			if (wr_commit && sel_cmp_a) begin
				cmp_a_reg <= merge16(cmp_a_reg, i_wb);
			end
			if (wr_commit && sel_cmp_b) begin
				cmp_b_reg <= merge16(cmp_b_reg, i_wb);
			end
			if (wr_lane0 && sel_mask) begin
				irq_mask_reg <= i_wb.dat[`FRT_BIT_CMP_A:`FRT_BIT_WRAP];
			end
			irq_stat_reg <= ev | (irq_stat_reg & ~stat_w1c[`FRT_BIT_CMP_A:`FRT_BIT_WRAP]);
		end
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

	// ==========================================================
	// Wishbone answer: ack one cycle after the request, for one cycle
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_flags) begin
			rd_mux = {28'h000_0000, flags_reg, clr_a_reg};
		end else if (sel_count) begin
			rd_mux = {16'h0000, count_reg};
		end else if (sel_cmp_a) begin
			rd_mux = {16'h0000, cmp_a_reg};
		end else if (sel_cmp_b) begin
			rd_mux = {16'h0000, cmp_b_reg};
		end else if (sel_mask) begin
			rd_mux = {28'h000_0000, irq_mask_reg, 1'b0};
		end else if (sel_stat) begin
			rd_mux = {28'h000_0000, irq_stat_reg, 1'b0};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (req && !ack_reg) begin
				dat_reg <= rd_mux;
			end
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = dat_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_arm_a;
		rd_commit && sel_flags && flags_reg.cmp_a;
	endsequence

	sequence s_zero_a;
		flag_wr && !i_wb.dat[`FRT_BIT_CMP_A] && !match_a;
	endsequence

	AST_MATCH_A: assert property (match_a |=> flags_reg.cmp_a)
		else $error("compare A match did not set its flag");
	AST_MATCH_B: assert property (match_b |=> flags_reg.cmp_b && irq_stat_reg.cmp_b)
		else $error("compare B match did not set its flag");
	AST_WRAP: assert property (tick && !clr_hit && !cnt_wr && count_reg == 16'hFFFF
			|=> flags_reg.wrap && count_reg == 16'h0000)
		else $error("wrap did not set flag or reach zero");
	// Read ack, one idle cycle, write request, then its ack edge where the zero lands
	AST_READ_THEN_ZERO: assert property (s_arm_a ##1 !req ##1 req ##1 s_zero_a
			|=> !flags_reg.cmp_a)
		else $error("flag A not cleared by read then write of zero");
	AST_NO_CLEAR_UNREAD: assert property (flags_reg.cmp_a && !armed_reg.cmp_a && flag_wr
			|=> flags_reg.cmp_a)
		else $error("flag A cleared without a prior read");
	AST_ONE_NO_SET: assert property (!flags_reg.wrap && !wrap |=> !flags_reg.wrap)
		else $error("wrap flag set without a wrap");
	AST_CLR_ON_A: assert property (match_a && clr_a_reg && !cnt_wr |=> count_reg == 16'h0000)
		else $error("counter not cleared on compare A");
	AST_COUNT_ON: assert property (tick && !clr_hit && !cnt_wr
			|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("counter did not step by one on a tick");
	AST_RSVD_ZERO: assert property (req && !ack_reg && sel_flags |=> o_wb_dat[7:4] == 4'h0)
		else $error("reserved status bits read nonzero");
	AST_ACK_PULSE: assert property (req && !ack_reg |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack not a single cycle pulse one cycle after request");

endmodule : free_running_timer_status

// >>> sim/test_free_running_timer_status.sv
// Self-checking bench of the free-running timer registers and interrupt
`timescale 1ns/10ps
`include "frt_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected %0t: got %h want %h", $time, (a), (e)); end end

module test_free_running_timer_status
	import frt_pkg::*;
;
	logic        i_clk     = 1'b0;
	logic        i_rst     = 1'b1;
	wb_req_t     wb        = '0;
	logic        ack;
	logic [31:0] rdat;
	logic        irq;
	logic [31:0] rd;
	int          err_count = 0;
	int          checked   = 0;

	always #25 i_clk = ~i_clk;

	free_running_timer_status #(.TICK_DIV(1)) u_free_running_timer_status (
		.i_clk(i_clk), .i_rst(i_rst), .i_wb(wb), .o_wb_ack(ack), .o_wb_dat(rdat), .o_irq(irq));

	// ==========================================================
	// Bus tasks
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge i_clk);
		wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: adr, dat: dat};
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			err_count++;
			$display("unexpected %0t: no ack", $time);
			stop_test();
		end
		rd = rdat;
		wb <= '0;
	endtask : xfer

	// ==========================================================
	// Tests
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		xfer(1'b0, `FRT_OFS_FLAGS, 32'h0);
		`CHK(rd, 32'h0000_0000)
		xfer(1'b0, `FRT_OFS_CMP_A, 32'h0);
		`CHK(rd, 32'h0000_FFFF)
		xfer(1'b0, 8'h20, 32'h0);
		`CHK(rd, 32'h0000_0000)
		$display("test reset done");
		// Count runs through FFFF, which also equals compare B
		xfer(1'b1, `FRT_OFS_CMP_A, 32'h0000_1000);
		xfer(1'b1, `FRT_OFS_COUNT, 32'h0000_FFF0);
		repeat (40) @(posedge i_clk);
		xfer(1'b0, `FRT_OFS_FLAGS, 32'h0);
		`CHK(rd, 32'h0000_0006)
		xfer(1'b1, `FRT_OFS_FLAGS, 32'h0000_00FF);
		xfer(1'b0, `FRT_OFS_FLAGS, 32'h0);
		`CHK(rd, 32'h0000_0007)
		xfer(1'b1, `FRT_OFS_FLAGS, 32'h0000_0001);
		xfer(1'b0, `FRT_OFS_FLAGS, 32'h0);
		`CHK(rd, 32'h0000_0001)
		// Zero written without a prior read must not clear
		xfer(1'b1, `FRT_OFS_COUNT, 32'h0000_FFF0);
		repeat (40) @(posedge i_clk);
		xfer(1'b1, `FRT_OFS_FLAGS, 32'h0000_0001);
		xfer(1'b0, `FRT_OFS_FLAGS, 32'h0);
		`CHK(rd, 32'h0000_0007)
		$display("test flags done");
		xfer(1'b1, `FRT_OFS_CMP_A, 32'h0000_0008);
		xfer(1'b1, `FRT_OFS_COUNT, 32'h0000_0000);
		repeat (40) @(posedge i_clk);
		xfer(1'b0, `FRT_OFS_FLAGS, 32'h0);
		`CHK(rd, 32'h0000_000F)
		xfer(1'b0, `FRT_OFS_COUNT, 32'h0);
		`CHK(rd[15:0] <= 16'h0008, 1'b1)
		xfer(1'b1, `FRT_OFS_FLAGS, 32'h0000_0000);
		repeat (40) @(posedge i_clk);
		xfer(1'b0, `FRT_OFS_COUNT, 32'h0);
		`CHK(rd[15:0] > 16'h0010, 1'b1)
		// Count passed compare A once; zero without a read keeps it, read then zero clears
		xfer(1'b1, `FRT_OFS_FLAGS, 32'h0000_0000);
		xfer(1'b0, `FRT_OFS_FLAGS, 32'h0);
		`CHK(rd, 32'h0000_0008)
		xfer(1'b1, `FRT_OFS_FLAGS, 32'h0000_0000);
		xfer(1'b0, `FRT_OFS_FLAGS, 32'h0);
		`CHK(rd, 32'h0000_0000)
		$display("test clear done");
		// Status is sticky from the events above
		xfer(1'b1, `FRT_OFS_IRQ_MASK, 32'h0000_0000);
		@(posedge i_clk);
		`CHK(irq, 1'b0)
		xfer(1'b1, `FRT_OFS_IRQ_MASK, 32'h0000_000E);
		@(posedge i_clk);
		`CHK(irq, 1'b1)
		xfer(1'b1, `FRT_OFS_IRQ_STAT, 32'h0000_000E);
		@(posedge i_clk);
		`CHK(irq, 1'b0)
		xfer(1'b0, `FRT_OFS_IRQ_STAT, 32'h0);
		`CHK(rd, 32'h0000_0000)
		$display("test irq done");
		stop_test();
	end
endmodule : test_free_running_timer_status
